// >>> dv/fcp_tb.sv
// Self-checking bench for the flash command, status and protection block.
// Assumes the register offsets and codes of fcp_pkg and a 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin \
   $display("unexpected %s exp %h got %h", nm, e, s); num_errors++; end end
module testbench;
   import fcp_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 0, rst_n = 0, dbg_prot_wr = 0, stop_req = 0, op_done = 0, op_blank = 0;
   logic clk_en = 1, backdoor_ok = 0;
   logic [7:0] dbg_prot_data = 8'h00, rdata, protection_register;
   logic [15:0] target_addr = 16'h0000;
   logic [1:0] security_code;
   fcp_bus_t bus = '0;
   fcp_op_t op;
   logic [7:0] exp_q[$], msk_q[$];
   logic pend = 0;
   int num_errors = 0, n_tests = 0, cyc = 0, seed = 88349;
   logic [7:0] codes[5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
   fcp_core i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rdata(rdata),
      .nonvolatile_protect_byte(8'h80), .dbg_prot_wr(dbg_prot_wr), .dbg_prot_data(dbg_prot_data),
      .target_addr(target_addr), .stop_req(stop_req), .op_done(op_done), .op_blank(op_blank),
      .backdoor_ok(backdoor_ok), .op(op), .security_code(security_code),
      .protection_register(protection_register));
   initial begin
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // Read monitor and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      pend <= bus.rd & rst_n;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   always @(negedge clk) begin
      if (pend) begin
         `CHK("rdata", exp_q.pop_front() & msk_q[0], rdata & msk_q.pop_front())
      end
   end
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask : rd
   task automatic dbg(input logic [7:0] d);
      @(posedge clk);
      dbg_prot_wr <= 1'b1;
      dbg_prot_data <= d;
      @(posedge clk);
      dbg_prot_wr <= 1'b0;
   endtask : dbg
   task automatic launch(input logic [7:0] c, output bit seen);
      wr(FCP_OFS_CMD, c);
      wr(FCP_OFS_STAT, 8'h80);
      seen = 0;
      repeat (10) begin
         @(posedge clk);
         #1;
         if (op.req === 1'b1) begin
            seen = 1;
            break;
         end
      end
   endtask : launch
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      bit seen;
      logic [15:0] ta;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      `CHK("prot", 8'h80, protection_register)
      rd(FCP_OFS_PROT, 8'h80, 8'hFF);
      wr(FCP_OFS_STAT, 8'h0B);
      rd(FCP_OFS_STAT, 8'hC0, 8'hFF);
      rd(3'h6, 8'h00, 8'hFF);
      $display("test reset done");
      wr(FCP_OFS_PROT, 8'hA0);
      rd(FCP_OFS_PROT, 8'h80, 8'hFF);
      wr(FCP_OFS_PROT, 8'h60);
      rd(FCP_OFS_PROT, 8'h60, 8'hFF);
      dbg(8'h61);
      wr(FCP_OFS_PROT, 8'h20);
      rd(FCP_OFS_PROT, 8'h61, 8'hFF);
      $display("test protection done");
      launch(FCP_BYTE_PROGRAM_CODE, seen);
      `CHK("no op", 1'b0, seen)
      rd(FCP_OFS_STAT, 8'h10, 8'h10);
      wr(FCP_OFS_STAT, 8'h00);
      rd(FCP_OFS_STAT, 8'h10, 8'h10);
      wr(FCP_OFS_STAT, 8'h10);
      rd(FCP_OFS_STAT, 8'h00, 8'h10);
      wr(FCP_OFS_CTRL, 8'h01);
      launch(8'h77, seen);
      `CHK("no op", 1'b0, seen)
      rd(FCP_OFS_STAT, 8'h10, 8'h10);
      wr(FCP_OFS_STAT, 8'h10);
      $display("test errors done");
      foreach (codes[i]) begin
         ta = 16'($random(seed));
         target_addr <= ta;
         op_blank <= (codes[i] == FCP_BLANK_CHECK_CODE);
         launch(codes[i], seen);
         `CHK("req", 1'b1, seen)
         `CHK("cmd", codes[i], op.cmd)
         `CHK("addr", ta, op.addr)
         rd(FCP_OFS_STAT, 8'h80, 8'hC0);
         repeat (22) @(posedge clk);
         op_done <= 1'b1;
         @(posedge clk);
         op_done <= 1'b0;
         repeat (3) @(posedge clk);
         rd(FCP_OFS_STAT, (codes[i] == 8'h05) ? 8'hC4 : 8'hC0, 8'hF4);
      end
      `CHK("sec", FCP_SEC_UNSECURED, security_code)
      $display("test commands done");
      dbg(8'h10);
      target_addr <= 16'hFE00;
      launch(FCP_BYTE_PROGRAM_CODE, seen);
      `CHK("no op", 1'b0, seen)
      rd(FCP_OFS_STAT, 8'h20, 8'h20);
      wr(FCP_OFS_STAT, 8'h20);
      rd(FCP_OFS_STAT, 8'h00, 8'h20);
      target_addr <= 16'h0000;
      launch(FCP_MASS_ERASE_CODE, seen);
      `CHK("no op", 1'b0, seen)
      wr(FCP_OFS_STAT, 8'h20);
      $display("test violation done");
      launch(FCP_BYTE_PROGRAM_CODE, seen);
      `CHK("req", 1'b1, seen)
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (3) @(posedge clk);
      rd(FCP_OFS_STAT, 8'h10, 8'h10);
      repeat (3) @(posedge clk);
      $display("test stop done");
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(FCP_OFS_PROT, 8'h80, 8'hFF);
      rd(FCP_OFS_SEC, 8'h00, 8'hFF);
      clk_en <= 1'b0;
      wr(FCP_OFS_PROT, 8'h20);
      clk_en <= 1'b1;
      rd(FCP_OFS_PROT, 8'h80, 8'hFF);
      @(posedge clk);
      backdoor_ok <= 1'b1;
      @(posedge clk);
      backdoor_ok <= 1'b0;
      rd(FCP_OFS_SEC, 8'h02, 8'hFF);
      $display("test reset and freeze done");
      conclude();
   end
endmodule : testbench
`default_nettype wire

// >>> rtl/fcp_core.sv
// Flash command, status and protection registers with a command sequencer.
// Assumes the array reports completion with op_done and blank results with op_blank.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module fcp_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register port
   input wire fcp_pkg::fcp_bus_t bus,
   output logic [7:0] rdata,
   // Reset-time load and debug access
   input wire logic [7:0] nonvolatile_protect_byte,
   input wire logic dbg_prot_wr,
   input wire logic [7:0] dbg_prot_data,
   // Array side
   input wire logic [15:0] target_addr,
   input wire logic stop_req,
   input wire logic op_done,
   input wire logic op_blank,
   input wire logic backdoor_ok,
   output fcp_pkg::fcp_op_t op,
   output logic [1:0] security_code,
   output logic [7:0] protection_register
);
   import fcp_pkg::*;

   fcp_state_all_t s_q, s_d;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic legal_cmd(input logic [7:0] c);
      legal_cmd = (c == FCP_BLANK_CHECK_CODE) || (c == FCP_BYTE_PROGRAM_CODE)
         || (c == FCP_BURST_PROGRAM_CODE) || (c == FCP_PAGE_ERASE_CODE)
         || (c == FCP_MASS_ERASE_CODE);
   endfunction : legal_cmd

   function automatic logic writes_array(input logic [7:0] c);
      writes_array = (c != FCP_BLANK_CHECK_CODE);
   endfunction : writes_array

   // Protected when enabled and address lies above the boundary in p[7:1]; mass erase always protected while enabled
   function automatic logic is_protected(input logic [7:0] p, input logic [7:0] c, input logic [15:0] a);
      if (p[FCP_PROT_DIS]) begin
         is_protected = 1'b0;
      end else if (c == FCP_MASS_ERASE_CODE) begin
         is_protected = 1'b1;
      end else begin
         is_protected = (a[15:9] > p[7:1]);
      end
   endfunction : is_protected

   logic wr_stat, wr_cmd, wr_prot, wr_ctrl, launch;
   always_comb begin
      wr_stat = bus.wr && (bus.addr == FCP_OFS_STAT);
      wr_cmd = bus.wr && (bus.addr == FCP_OFS_CMD);
      wr_prot = bus.wr && (bus.addr == FCP_OFS_PROT);
      wr_ctrl = bus.wr && (bus.addr == FCP_OFS_CTRL);
      launch = wr_stat && bus.wdata[FCP_ST_CBEF] && s_q.cbef;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic bad;
      logic viol;
      bad = 1'b0;
      viol = 1'b0;
      s_d = s_q;
      s_d.op.req = 1'b0;
      // Flags: software clear first so hardware set wins afterwards
      if (wr_stat && bus.wdata[FCP_ST_PVIOL]) begin
         s_d.pviol = 1'b0;
      end
      if (wr_stat && bus.wdata[FCP_ST_ACCERR]) begin
         s_d.accerr = 1'b0;
      end
      if (wr_ctrl) begin
         s_d.divok = bus.wdata[FCP_CTRL_DIVOK];
      end
      // Protection register updates
      if (dbg_prot_wr) begin
         s_d.prot = dbg_prot_data;
      end else if (wr_prot && !s_q.prot[FCP_PROT_DIS]) begin
         if (bus.wdata[7:1] < s_q.prot[7:1]) begin
            s_d.prot[7:1] = bus.wdata[7:1];
         end
      end
      if (wr_cmd) begin
         s_d.cmd = bus.wdata;
      end
      // Launch
      if (launch) begin
         if (!legal_cmd(s_q.cmd)) begin
            bad = 1'b1;
         end else if (writes_array(s_q.cmd) && !s_q.divok) begin
            bad = 1'b1;
         end else if (s_q.st != FCP_IDLE && s_q.cmd != FCP_BURST_PROGRAM_CODE) begin
            bad = 1'b1;
         end else if (writes_array(s_q.cmd) && is_protected(s_q.prot, s_q.cmd, target_addr)) begin
            viol = 1'b1;
         end
         if (bad) begin
            s_d.accerr = 1'b1;
         end else if (viol) begin
            s_d.pviol = 1'b1;
         end else begin
            s_d.cbef = 1'b0;
            s_d.ccf = 1'b0;
            s_d.blank = 1'b0;
            s_d.pend = 1'b1;
            s_d.pcmd = s_q.cmd;
            s_d.paddr = target_addr;
         end
      end
      // Sequencer
      case (s_q.st)
         FCP_IDLE: begin
            if (s_q.pend) begin
               s_d.st = FCP_LOAD;
            end
         end
         FCP_LOAD: begin
            // Transfer buffered command to the array, freeing the buffer
            s_d.op.req = 1'b1;
            s_d.op.cmd = s_q.pcmd;
            s_d.op.addr = s_q.paddr;
            s_d.pend = launch && !bad && !viol;
            s_d.cbef = !(launch && !bad && !viol);
            s_d.cnt = FCP_OP_CYCLES;
            s_d.st = FCP_BUSY;
         end
         FCP_BUSY: begin
            if (s_q.cnt != 8'h00) begin
               s_d.cnt = s_q.cnt - 8'h01;
            end
            if (s_q.cnt == 8'h00 && op_done) begin
               if (s_q.op.cmd == FCP_BLANK_CHECK_CODE && op_blank) begin
                  s_d.blank = 1'b1;
                  s_d.sec = FCP_SEC_UNSECURED;
               end
               s_d.st = s_d.pend ? FCP_LOAD : FCP_IDLE;
               if (!s_d.pend) begin
                  s_d.ccf = 1'b1;
               end
            end
         end
         default: begin
            s_d.st = FCP_IDLE;
         end
      endcase
      // Stop during a command aborts it
      if (stop_req && s_q.st != FCP_IDLE) begin
         s_d.accerr = 1'b1;
         s_d.st = FCP_IDLE;
         s_d.pend = 1'b0;
         s_d.cbef = 1'b1;
         s_d.ccf = 1'b1;
      end
      if (backdoor_ok) begin
         s_d.sec = FCP_SEC_UNSECURED;
      end
      // Read data, one cycle later
      s_d.rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            FCP_OFS_PROT: s_d.rdata = s_q.prot;
            FCP_OFS_STAT: s_d.rdata = {s_q.cbef, s_q.ccf, s_q.pviol, s_q.accerr, 1'b0, s_q.blank, 2'b00} &
               FCP_STAT_MASK;
            FCP_OFS_CMD: s_d.rdata = s_q.cmd;
            FCP_OFS_CTRL: s_d.rdata = {7'h00, s_q.divok};
            FCP_OFS_SEC: s_d.rdata = {6'h00, s_q.sec};
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= FCP_IDLE;
         s_q.prot <= nonvolatile_protect_byte;
         s_q.cbef <= FCP_STAT_RST[FCP_ST_CBEF];
         s_q.ccf <= FCP_STAT_RST[FCP_ST_CCF];
         s_q.sec <= FCP_SEC_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   always_comb begin
      rdata = s_q.rdata;
      op = s_q.op;
      security_code = s_q.sec;
      protection_register = s_q.prot;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_rsvd_zero;
      @(posedge clk) disable iff (!rst_n)
      $past(bus.rd) && $past(bus.addr) == FCP_OFS_STAT && $past(clk_en) |-> (rdata & 8'h0B) == 8'h00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved status bits nonzero");

   property p_prot_frozen;
      @(posedge clk) disable iff (!rst_n)
      s_q.prot[FCP_PROT_DIS] && !dbg_prot_wr && clk_en |=> $stable(s_q.prot);
   endproperty
   a_prot_frozen: assert property (p_prot_frozen) else $error("Protection changed while disabled");

   property p_prot_incr;
      @(posedge clk) disable iff (!rst_n)
      !dbg_prot_wr && clk_en |=> s_q.prot[7:1] <= $past(s_q.prot[7:1]);
   endproperty
   a_prot_incr: assert property (p_prot_incr) else $error("Protection was lowered");

   property p_illegal_err;
      @(posedge clk) disable iff (!rst_n)
      launch && clk_en && !legal_cmd(s_q.cmd) |=> s_q.accerr && s_q.cbef;
   endproperty
   a_illegal_err: assert property (p_illegal_err) else $error("Illegal command not flagged");

   property p_viol;
      @(posedge clk) disable iff (!rst_n)
      launch && clk_en && legal_cmd(s_q.cmd) && s_q.divok && s_q.st == FCP_IDLE && writes_array(s_q.cmd)
         && is_protected(s_q.prot, s_q.cmd, target_addr) |=> s_q.pviol && !s_q.pend;
   endproperty
   a_viol: assert property (p_viol) else $error("Protection violation missed");

   sequence s_good_launch;
      launch && clk_en && s_q.st == FCP_IDLE && legal_cmd(s_q.cmd) && !writes_array(s_q.cmd);
   endsequence
   property p_launch_ccf;
      @(posedge clk) disable iff (!rst_n)
      s_good_launch |=> !s_q.ccf && !s_q.blank && !s_q.cbef;
   endproperty
   a_launch_ccf: assert property (p_launch_ccf) else $error("Launch did not clear flags");

   property p_accerr_hold;
      @(posedge clk) disable iff (!rst_n)
      s_q.accerr && clk_en && !(wr_stat && bus.wdata[FCP_ST_ACCERR]) |=> s_q.accerr;
   endproperty
   a_accerr_hold: assert property (p_accerr_hold) else $error("Access error lost");

   property p_blank_sec;
      @(posedge clk) disable iff (!rst_n)
      $rose(s_q.blank) |-> security_code == FCP_SEC_UNSECURED;
   endproperty
   a_blank_sec: assert property (p_blank_sec) else $error("Blank pass left device secure");

   property p_rdata_idle;
      @(posedge clk) disable iff (!rst_n)
      !$past(bus.rd) && $past(clk_en) |-> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside read cycle");

   property p_pviol_hold;
      @(posedge clk) disable iff (!rst_n)
      s_q.pviol && clk_en && !(wr_stat && bus.wdata[FCP_ST_PVIOL]) |=> s_q.pviol;
   endproperty
   a_pviol_hold: assert property (p_pviol_hold) else $error("Violation flag lost");

   property p_div_err;
      @(posedge clk) disable iff (!rst_n)
      launch && clk_en && legal_cmd(s_q.cmd) && writes_array(s_q.cmd) && !s_q.divok |=> s_q.accerr;
   endproperty
   a_div_err: assert property (p_div_err) else $error("Divider fault not flagged");

   property p_busy_reject;
      @(posedge clk) disable iff (!rst_n)
      launch && clk_en && s_q.st != FCP_IDLE && s_q.cmd != FCP_BURST_PROGRAM_CODE |=> s_q.accerr;
   endproperty
   a_busy_reject: assert property (p_busy_reject) else $error("Unbuffered command accepted");

   // ----------------------------------------
   // Sequencer checks
   // ----------------------------------------
   property p_req_pulse;
      @(posedge clk) disable iff (!rst_n)
      op.req && clk_en |=> !op.req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("Array request longer than one cycle");

   property p_load_frees;
      @(posedge clk) disable iff (!rst_n)
      s_q.st == FCP_LOAD && clk_en && !stop_req |=> op.req && s_q.st == FCP_BUSY;
   endproperty
   a_load_frees: assert property (p_load_frees) else $error("Buffered command not transferred");

   property p_cbef_guard;
      @(posedge clk) disable iff (!rst_n)
      !s_q.cbef && clk_en && s_q.st != FCP_LOAD && !stop_req |=> !s_q.cbef;
   endproperty
   a_cbef_guard: assert property (p_cbef_guard) else $error("Buffer freed without transfer");

   property p_stop_err;
      @(posedge clk) disable iff (!rst_n)
      stop_req && s_q.st != FCP_IDLE && clk_en |=> s_q.accerr && s_q.ccf && s_q.cbef;
   endproperty
   a_stop_err: assert property (p_stop_err) else $error("Stop during command not flagged");

   property p_ccf_busy;
      @(posedge clk) disable iff (!rst_n)
      s_q.st == FCP_BUSY |-> !s_q.ccf;
   endproperty
   a_ccf_busy: assert property (p_ccf_busy) else $error("Completion flag set while busy");

   // Final cycle of a running command
   sequence s_op_end;
      s_q.st == FCP_BUSY && s_q.cnt == 8'h00 && op_done && clk_en && !stop_req;
   endsequence

   property p_ccf_done;
      @(posedge clk) disable iff (!rst_n)
      s_op_end ##0 (!s_q.pend && !launch) |=> s_q.ccf && s_q.st == FCP_IDLE;
   endproperty
   a_ccf_done: assert property (p_ccf_done) else $error("Completion flag not set at end");

   property p_blank_set;
      @(posedge clk) disable iff (!rst_n)
      s_op_end ##0 (s_q.op.cmd == FCP_BLANK_CHECK_CODE && op_blank) |=> s_q.blank
         && security_code == FCP_SEC_UNSECURED;
   endproperty
   a_blank_set: assert property (p_blank_set) else $error("Blank pass not recorded");

   property p_min_time;
      @(posedge clk) disable iff (!rst_n)
      s_q.st == FCP_BUSY && s_q.cnt != 8'h00 && clk_en && !stop_req |=> s_q.st == FCP_BUSY;
   endproperty
   a_min_time: assert property (p_min_time) else $error("Command ended before minimum time");

   property p_backdoor;
      @(posedge clk) disable iff (!rst_n)
      backdoor_ok && clk_en |=> security_code == FCP_SEC_UNSECURED;
   endproperty
   a_backdoor: assert property (p_backdoor) else $error("Key match left device secure");

   property p_sec_hold;
      @(posedge clk) disable iff (!rst_n)
      !backdoor_ok && clk_en && !(s_q.st == FCP_BUSY && op_done) |=> $stable(security_code);
   endproperty
   a_sec_hold: assert property (p_sec_hold) else $error("Security code changed unprompted");
endmodule : fcp_core
`default_nettype wire

// >>> rtl/fcp_pkg.sv
// Package for the flash command, status and protection block.
// Assumes an 8-bit register port and a 10 MHz bus clock.
package fcp_pkg;
   // ----------------------------------------
   // Register indices
   // ----------------------------------------
   localparam logic [2:0] FCP_OFS_PROT = 3'h0;
   localparam logic [2:0] FCP_OFS_STAT = 3'h1;
   localparam logic [2:0] FCP_OFS_CMD = 3'h2;
   localparam logic [2:0] FCP_OFS_CTRL = 3'h3;
   localparam logic [2:0] FCP_OFS_SEC = 3'h4;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int FCP_PROT_DIS = 0;
   localparam int FCP_ST_CBEF = 7;
   localparam int FCP_ST_CCF = 6;
   localparam int FCP_ST_PVIOL = 5;
   localparam int FCP_ST_ACCERR = 4;
   localparam int FCP_ST_BLANK = 2;
   localparam int FCP_CTRL_DIVOK = 0;
   localparam logic [7:0] FCP_STAT_MASK = 8'hF4;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] FCP_BLANK_CHECK_CODE = 8'h05;
   localparam logic [7:0] FCP_BYTE_PROGRAM_CODE = 8'h20;
   localparam logic [7:0] FCP_BURST_PROGRAM_CODE = 8'h25;
   localparam logic [7:0] FCP_PAGE_ERASE_CODE = 8'h40;
   localparam logic [7:0] FCP_MASS_ERASE_CODE = 8'h41;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [7:0] FCP_STAT_RST = 8'hC0;
   localparam logic [1:0] FCP_SEC_UNSECURED = 2'h2;
   localparam logic [1:0] FCP_SEC_RST = 2'h0;
   localparam int FCP_CLK_NS = 100;
   localparam int FCP_OP_TIME_NS = 2000;
   localparam logic [7:0] FCP_OP_CYCLES = 8'((FCP_OP_TIME_NS + FCP_CLK_NS - 1) / FCP_CLK_NS);

   typedef enum {FCP_IDLE, FCP_LOAD, FCP_BUSY} fcp_state_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fcp_bus_t;

   typedef struct packed {
      logic req;
      logic [7:0] cmd;
      logic [15:0] addr;
   } fcp_op_t;

   typedef struct packed {
      fcp_state_t st;
      logic [7:0] prot;
      logic cbef;
      logic ccf;
      logic pviol;
      logic accerr;
      logic blank;
      logic divok;
      logic [7:0] cmd;
      logic [1:0] sec;
      logic pend;
      logic [7:0] pcmd;
      logic [15:0] paddr;
      logic [7:0] cnt;
      logic [7:0] rdata;
      fcp_op_t op;
   } fcp_state_all_t;
endpackage : fcp_pkg
